// *** verilog/irq_map.svh ***
`ifndef IRQ_MAP_SVH
`define IRQ_MAP_SVH

// Register byte offsets
`define OFS_IRQ_ENABLE   12'h000
`define OFS_IRQ_FLAG     12'h004
`define OFS_SRC_FLAG     12'h008
`define OFS_SRC_ENABLE   12'h00c
`define OFS_TICK_CTRL    12'h010
`define OFS_IRQ_STATUS   12'h014

// Direct and group source indices (flag and enable bit positions)
`define SRC_CMP          0
`define SRC_CONV         1
`define SRC_TICK0        2
`define SRC_TICK1        3
`define SRC_GRP0         4
`define SRC_GRP1         5
`define SRC_GRP2         6
`define NUM_SRC          7
`define BIT_GLOBAL_EN    7

// Contained source positions in the source flag/enable registers
`define BIT_LOW_SUPPLY   6
`define BIT_NV_DONE      7
`define NUM_TIMERS       3

// Tick control fields
`define TICK_ON_BIT      7
`define TICK_CLKSEL_BIT  6
`define TICK1_SEL_HI     5
`define TICK1_SEL_LO     4
`define TICK_XTAL_BIT    3
`define TICK0_SEL_HI     2
`define TICK0_SEL_LO     0
`define TICK_CTRL_RESET  8'h37

// System clock divider for the tick source and the shortest and longest periods
`define SYS_TICK_DIV     4
`define TICK0_MIN_LOG2   8
`define TICK1_MIN_LOG2   12
`define TICK_MAX_LOG2    15

`endif

// *** verilog/irq_pkg.sv ***
package irq_pkg;

  typedef enum logic [3:0] {
    VEC_NONE  = 4'b0000,
    VEC_CMP   = 4'b0001,
    VEC_CONV  = 4'b0010,
    VEC_TICK0 = 4'b0011,
    VEC_TICK1 = 4'b0100,
    VEC_GRP0  = 4'b0101,
    VEC_GRP1  = 4'b0110,
    VEC_GRP2  = 4'b0111
  } vector_t;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_DATA = 1'b1
  } bus_state_t;

  typedef logic [2:0] tick0_sel_t;
  typedef logic [1:0] tick1_sel_t;

endpackage

// *** verilog/tick_if.sv ***
`timescale 1ns/1ns

interface tick_if;
  import irq_pkg::*;

  logic       tick_timers_on;
  logic       tick_clock_select;
  tick0_sel_t tick0_period_select;
  tick1_sel_t tick1_period_select;
  logic       tick0_overflow;
  logic       tick1_overflow;

  modport ctrl
  (
    output tick_timers_on,
    output tick_clock_select,
    output tick0_period_select,
    output tick1_period_select,
    input  tick0_overflow,
    input  tick1_overflow
  );

  modport timer
  (
    input  tick_timers_on,
    input  tick_clock_select,
    input  tick0_period_select,
    input  tick1_period_select,
    output tick0_overflow,
    output tick1_overflow
  );
endinterface

// *** verilog/tick_divider.sv ***
`timescale 1ns/1ns
`include "irq_map.svh"

module tick_divider
  import irq_pkg::*;
#(
  parameter int CNT_W = `TICK_MAX_LOG2
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic dedicated_tick_clock,
  tick_if.timer     tb
);

  // One counter serves every period, so its width must match the longest
  if (CNT_W != `TICK_MAX_LOG2)
  begin
    $error("tick_divider: CNT_W must equal the longest period");
  end

  logic [2:0]       tick_sync;
  logic             tick_stable;
  logic [1:0]       sys_div;
  logic             sys_quarter;
  logic             tick_en;
  logic [CNT_W-1:0] cnt;

  // True when the low `bits` counter bits are all ones
  function automatic logic all_ones(input logic [CNT_W-1:0] c,
                                    input int bits);
    logic r;
    r = 1'b1;
    for (int i = 0; i < CNT_W; i++)
      if (i < bits && !c[i])
        r = 1'b0;
    return r;
  endfunction

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_sync <= 3'b000;
    else
      tick_sync <= {tick_sync[1:0], dedicated_tick_clock};
  end

  // A pin level counts once the second and third stage agree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tick_stable <= 1'b0;
    else if (tick_sync[1] == tick_sync[2])
      tick_stable <= tick_sync[2];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sys_div <= 2'b00;
    else
      sys_div <= sys_div + 2'b01;
  end

  assign sys_quarter = (sys_div == 2'(`SYS_TICK_DIV - 1));

  always_comb
  begin
    if (tb.tick_clock_select)
      tick_en = sys_quarter;
    else
      tick_en = (tick_sync[1] == tick_sync[2]) && tick_sync[2]
                && !tick_stable;
  end

  // Both timers share one counter, so both stop when disabled
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt <= '0;
    else if (!tb.tick_timers_on)
      cnt <= '0;
    else if (tick_en)
      cnt <= cnt + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tb.tick0_overflow <= 1'b0;
      tb.tick1_overflow <= 1'b0;
    end
    else
    begin
      tb.tick0_overflow <= tb.tick_timers_on && tick_en
        && all_ones(cnt, `TICK0_MIN_LOG2
                    + int'(tb.tick0_period_select));
      tb.tick1_overflow <= tb.tick_timers_on && tick_en
        && all_ones(cnt, `TICK1_MIN_LOG2
                    + int'(tb.tick1_period_select));
    end
  end

endmodule

// *** verilog/irq_controller.sv ***
// Function
// - Comparator flag sets whenever the comparator output changes state.
// - Comparator vectors only with global and own enable, stack not full.
// - Servicing comparator clears its flag and the global enable.
// - Three group interrupts fed by timer, supply and memory flags.
// - Group flag sets when any individually enabled contained source occurs.
// - Group vectors when enabled, stack not full, contained source occurs.
// - Group service clears group flag and global only; sources stay.
// - Converter-done flag sets when a conversion finishes.
// - Converter vectors with enables and stack room; service clears flags.
// - Each tick flag sets when its divider overflows.
// - Tick vectors with enables and stack room; service clears flags.
// - Tick control bit 7 enables or disables both tick timers.
// - Tick control bit 6 picks tick clock or system clock over four.
// - Bits 5..4 pick second tick period 4096 to 32768 cycles.
// - Bits 2..0 pick first tick period 256 to 32768 cycles.
// - Tick control bit 3 selects slow crystal low-power start-up.
// - Memory write-done flag sets when a write cycle ends.
// - Write-done needs global, own, group enables; software clears it.
// - Low-supply flag sets when the supply monitor sees low voltage.
// - Low-supply needs global, own, group enables; software clears it.
// - Each timer has period and compare-A flags and enables.
// - Timer interrupts need all three enables; software clears flags.
// - Any flag rising from low to high wakes, enabled or not.
// - Return-from-interrupt sets the global enable again; plain return not.
`timescale 1ns/1ns
`include "irq_map.svh"

module irq_controller
  import irq_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST_N,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        COMPARATOR_OUT,
  input  wire logic        CONV_DONE,
  input  wire logic        NV_WRITE_DONE,
  input  wire logic        LOW_SUPPLY_DETECT,
  input  wire logic [2:0]  TIMER_PERIOD_MATCH,
  input  wire logic [2:0]  TIMER_COMPARE_A,
  input  wire logic        DEDICATED_TICK_CLOCK,
  input  wire logic        STACK_FULL,
  input  wire logic        RETURN_FROM_INTERRUPT,
  output logic             IRQ_CALL,
  output vector_t          IRQ_VECTOR,
  output logic             WAKE,
  output logic             SLOW_XTAL_LOW_POWER
);

  localparam int NS = `NUM_SRC;

  tick_if tick_bus ();

  bus_state_t  bus_state;
  logic [11:0] bus_addr;
  logic        bus_write;
  logic        bus_take;
  logic        wr_strobe;

  logic          global_irq_enable;
  logic [NS-1:0] src_enable;
  logic [NS-1:0] src_flag;
  logic [7:0]    con_flag;
  logic [7:0]    con_enable;
  logic [7:0]    tick_timer_control;
  vector_t       last_vector;

  logic [2:0]    cmp_sync;
  logic          cmp_stable;
  logic          cmp_change;
  logic [7:0]    con_set;
  logic [NS-1:0] set_event;
  logic [NS-1:0] pending;
  logic [NS-1:0] grant;
  logic          service;
  logic [14:0]   all_flags;
  logic [14:0]   prev_flags;
  logic [31:0]   rd_value;

  // Fixed priority: comparator, group 0, converter, group 1, tick 0,
  // tick 1, group 2. Only one bit survives so the rest stay pending.
  function automatic logic [NS-1:0] pick(input logic [NS-1:0] req);
    logic [NS-1:0] g;
    g = '0;
    if (req[`SRC_CMP])
      g[`SRC_CMP] = 1'b1;
    else if (req[`SRC_GRP0])
      g[`SRC_GRP0] = 1'b1;
    else if (req[`SRC_CONV])
      g[`SRC_CONV] = 1'b1;
    else if (req[`SRC_GRP1])
      g[`SRC_GRP1] = 1'b1;
    else if (req[`SRC_TICK0])
      g[`SRC_TICK0] = 1'b1;
    else if (req[`SRC_TICK1])
      g[`SRC_TICK1] = 1'b1;
    else if (req[`SRC_GRP2])
      g[`SRC_GRP2] = 1'b1;
    return g;
  endfunction

  function automatic vector_t encode(input logic [NS-1:0] g);
    vector_t v;
    v = VEC_NONE;
    if (g[`SRC_CMP])
      v = VEC_CMP;
    else if (g[`SRC_CONV])
      v = VEC_CONV;
    else if (g[`SRC_TICK0])
      v = VEC_TICK0;
    else if (g[`SRC_TICK1])
      v = VEC_TICK1;
    else if (g[`SRC_GRP0])
      v = VEC_GRP0;
    else if (g[`SRC_GRP1])
      v = VEC_GRP1;
    else if (g[`SRC_GRP2])
      v = VEC_GRP2;
    return v;
  endfunction

  // Software writes to a flag register, hardware sets win over clears
  function automatic logic [7:0] flag_next(input logic [7:0] cur,
                                           input logic       wr,
                                           input logic [7:0] wdata,
                                           input logic [7:0] clr,
                                           input logic [7:0] set);
    logic [7:0] n;
    n = wr ? wdata : cur;
    n = (n & ~clr) | set;
    return n;
  endfunction

  tick_divider #(
    .CNT_W (`TICK_MAX_LOG2)
  ) u_tick (
    .clk                  (CLK_SYS),
    .rst_n                (RST_N),
    .dedicated_tick_clock (DEDICATED_TICK_CLOCK),
    .tb                   (tick_bus.timer)
  );

  assign tick_bus.tick_timers_on      = tick_timer_control[`TICK_ON_BIT];
  assign tick_bus.tick_clock_select   = tick_timer_control[`TICK_CLKSEL_BIT];
  assign tick_bus.tick0_period_select =
    tick_timer_control[`TICK0_SEL_HI:`TICK0_SEL_LO];
  assign tick_bus.tick1_period_select =
    tick_timer_control[`TICK1_SEL_HI:`TICK1_SEL_LO];

  // Bus slave: one wait state so read data can come from a flop
  assign bus_take  = HSEL && HTRANS[1] && HREADY;
  assign wr_strobe = (bus_state == BUS_DATA) && bus_write;

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      bus_state <= BUS_IDLE;
      bus_addr  <= 12'h000;
      bus_write <= 1'b0;
      HREADYOUT <= 1'b1;
    end
    else
    begin
      case (bus_state)
        BUS_IDLE:
        begin
          if (bus_take)
          begin
            bus_state <= BUS_DATA;
            bus_addr  <= HADDR[11:0];
            bus_write <= HWRITE;
            HREADYOUT <= 1'b0;
          end
        end
        BUS_DATA:
        begin
          bus_state <= BUS_IDLE;
          HREADYOUT <= 1'b1;
        end
        default:
        begin
          bus_state <= BUS_IDLE;
          HREADYOUT <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      HRESP <= 1'b0;
    else
      HRESP <= 1'b0;
  end

  always_comb
  begin
    if (bus_addr == `OFS_IRQ_ENABLE)
      rd_value = {24'h000000, global_irq_enable, src_enable};
    else if (bus_addr == `OFS_IRQ_FLAG)
      rd_value = {24'h000000, 1'b0, src_flag};
    else if (bus_addr == `OFS_SRC_FLAG)
      rd_value = {24'h000000, con_flag};
    else if (bus_addr == `OFS_SRC_ENABLE)
      rd_value = {24'h000000, con_enable};
    else if (bus_addr == `OFS_TICK_CTRL)
      rd_value = {24'h000000, tick_timer_control};
    else if (bus_addr == `OFS_IRQ_STATUS)
      rd_value = {26'h0000000, global_irq_enable, STACK_FULL, last_vector};
    else
      rd_value = 32'h00000000;
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      HRDATA <= 32'h00000000;
    else if (bus_state == BUS_DATA && !bus_write)
      HRDATA <= rd_value;
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      tick_timer_control <= `TICK_CTRL_RESET;
    else if (wr_strobe && bus_addr == `OFS_TICK_CTRL)
      tick_timer_control <= HWDATA[7:0];
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      SLOW_XTAL_LOW_POWER <= 1'b0;
    else
      SLOW_XTAL_LOW_POWER <= tick_timer_control[`TICK_XTAL_BIT];
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      con_enable <= 8'h00;
    else if (wr_strobe && bus_addr == `OFS_SRC_ENABLE)
      con_enable <= HWDATA[7:0];
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      src_enable <= '0;
    else if (wr_strobe && bus_addr == `OFS_IRQ_ENABLE)
      src_enable <= HWDATA[NS-1:0];
  end

  // Comparator output is asynchronous to this clock
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      cmp_sync <= 3'b000;
    else
      cmp_sync <= {cmp_sync[1:0], COMPARATOR_OUT};
  end

  assign cmp_change = (cmp_sync[1] == cmp_sync[2])
                      && (cmp_sync[2] != cmp_stable);

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      cmp_stable <= 1'b0;
    else if (cmp_change)
      cmp_stable <= cmp_sync[2];
  end

  // Contained sources: bits 2n/2n+1 timer n period/compare-A
  always_comb
  begin
    for (int n = 0; n < `NUM_TIMERS; n++)
    begin
      con_set[2*n]   = TIMER_PERIOD_MATCH[n];
      con_set[2*n+1] = TIMER_COMPARE_A[n];
    end
    con_set[`BIT_LOW_SUPPLY] = LOW_SUPPLY_DETECT;
    con_set[`BIT_NV_DONE]    = NV_WRITE_DONE;
  end

  // Source flags are never cleared by servicing; software clears them
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      con_flag <= 8'h00;
    else
      con_flag <= flag_next(con_flag,
                            wr_strobe && bus_addr == `OFS_SRC_FLAG,
                            HWDATA[7:0], 8'h00, con_set);
  end

  always_comb
  begin
    set_event              = '0;
    set_event[`SRC_CMP]    = cmp_change;
    set_event[`SRC_CONV]   = CONV_DONE;
    set_event[`SRC_TICK0]  = tick_bus.tick0_overflow;
    set_event[`SRC_TICK1]  = tick_bus.tick1_overflow;
    // A contained source must also be individually enabled
    set_event[`SRC_GRP0]   = |(con_set[1:0] & con_enable[1:0]);
    set_event[`SRC_GRP1]   = |(con_set[5:2] & con_enable[5:2]);
    set_event[`SRC_GRP2]   = |(con_set[7:6] & con_enable[7:6]);
  end

  // Stack full holds every request back until the core pops it
  assign pending = src_flag & src_enable;
  assign service = global_irq_enable && !STACK_FULL
                   && (|pending);
  assign grant   = service ? pick(pending) : '0;

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      src_flag <= '0;
    else
      src_flag <= NS'(flag_next({1'b0, src_flag},
                                wr_strobe && bus_addr == `OFS_IRQ_FLAG,
                                HWDATA[7:0], {1'b0, grant},
                                {1'b0, set_event}));
  end

  // A service in the same cycle as a return leaves the enable cleared
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      global_irq_enable <= 1'b0;
    else if (service)
      global_irq_enable <= 1'b0;
    else if (RETURN_FROM_INTERRUPT)
      global_irq_enable <= 1'b1;
    else if (wr_strobe && bus_addr == `OFS_IRQ_ENABLE)
      global_irq_enable <= HWDATA[`BIT_GLOBAL_EN];
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      IRQ_CALL    <= 1'b0;
      IRQ_VECTOR  <= VEC_NONE;
      last_vector <= VEC_NONE;
    end
    else
    begin
      IRQ_CALL   <= service;
      IRQ_VECTOR <= encode(grant);
      if (service)
        last_vector <= encode(grant);
    end
  end

  // Wake ignores every enable
  assign all_flags = {con_flag, src_flag};

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      prev_flags <= '0;
      WAKE       <= 1'b0;
    end
    else
    begin
      prev_flags <= all_flags;
      WAKE       <= |(all_flags & ~prev_flags);
    end
  end

endmodule

// *** tb/irq_monitor.sv ***
`timescale 1ns/1ns

module irq_monitor
  import irq_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        RST_N,
  input wire logic        HSEL,
  input wire logic [1:0]  HTRANS,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        STACK_FULL,
  input wire logic        RETURN_FROM_INTERRUPT,
  input wire logic        IRQ_CALL,
  input wire logic [3:0]  IRQ_VECTOR,
  input wire logic        SLOW_XTAL_LOW_POWER
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  sequence taken_s;
    HSEL && HTRANS[1] && HREADY;
  endsequence
  // Nothing that could set the global enable again
  sequence quiet_s;
    !RETURN_FROM_INTERRUPT && !(HSEL && HTRANS[1]);
  endsequence
  sequence one_wait_s;
    !HREADYOUT ##1 HREADYOUT;
  endsequence

  call_pulse_a: assert property (IRQ_CALL |=> !IRQ_CALL)
    else $error("vector call longer than one cycle");
  vector_code_a: assert property (IRQ_CALL ==
    (IRQ_VECTOR != VEC_NONE))
    else $error("vector code not tied to call pulse");
  stack_block_a: assert property (IRQ_CALL |-> !$past(STACK_FULL))
    else $error("call taken while stack full");
  global_block_a: assert property (IRQ_CALL ##1 quiet_s [*4]
    |=> !IRQ_CALL)
    else $error("second call without global enable set again");
  bus_okay_a: assert property (HRESP == 1'b0)
    else $error("bus response not okay");
  bus_wait_a: assert property (taken_s |=> one_wait_s)
    else $error("transfer not answered after one wait");
  wait_cause_a: assert property ($fell(HREADYOUT)
    |-> $past(HSEL && HTRANS[1] && HREADY))
    else $error("wait state without transfer");
  rdata_hold_a: assert property ($changed(HRDATA) |-> $past(!HREADYOUT))
    else $error("read data moved outside a transfer");
  xtal_copy_a: assert property ($changed(SLOW_XTAL_LOW_POWER)
    |-> $past(!HREADYOUT) || $past(!HREADYOUT, 2))
    else $error("crystal control moved without a write");
endmodule

bind irq_controller irq_monitor u_mon
(
  .CLK_SYS               (CLK_SYS),
  .RST_N                 (RST_N),
  .HSEL                  (HSEL),
  .HTRANS                (HTRANS),
  .HREADY                (HREADY),
  .HRDATA                (HRDATA),
  .HREADYOUT             (HREADYOUT),
  .HRESP                 (HRESP),
  .STACK_FULL            (STACK_FULL),
  .RETURN_FROM_INTERRUPT (RETURN_FROM_INTERRUPT),
  .IRQ_CALL              (IRQ_CALL),
  .IRQ_VECTOR            (IRQ_VECTOR),
  .SLOW_XTAL_LOW_POWER   (SLOW_XTAL_LOW_POWER)
);

// *** tb/core_model.sv ***
`timescale 1ns/1ns

module core_model
#(
  parameter int RET_DELAY = 4
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic irq_call,
  input  wire logic auto_ret,
  input  wire logic hold_full,
  output logic      stack_full,
  output logic      ret_pulse
);
  int wait_cnt;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stack_full <= 1'b0;
      ret_pulse  <= 1'b0;
      wait_cnt   <= 0;
    end
    else
    begin
      stack_full <= hold_full;
      ret_pulse  <= 1'b0;
      if (irq_call)
        wait_cnt <= RET_DELAY;
      else if (wait_cnt != 0)
      begin
        wait_cnt <= wait_cnt - 1;
        // Plain return leaves global clear; this pulse or a bus write of the global enable re-arms
        if (wait_cnt == 1 && auto_ret)
          ret_pulse <= 1'b1;
      end
    end
  end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`include "irq_map.svh"

module tb_top;
  import irq_pkg::*;
  logic        clk_sys = 0, rst_n = 0, hsel = 0, hwrite = 0;
  logic        tick_clk = 0, cmp = 0, auto_ret = 0, hold_full = 0;
  logic [1:0]  htrans = '0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [8:0]  ev = '0;
  logic        hreadyout, hresp, irq_call, wake, xtal, full, ret;
  vector_t     irq_vector;
  int          num_errors = 0, checks = 0, cyc = 0, wakes = 0, t0;

  always #5 clk_sys = ~clk_sys;
  // Tick pin at a fifth of the system rate, off the clock edges; each
  // level spans at least two samples so the pin filter passes it
  initial
  begin
    #2;
    forever #25 tick_clk = ~tick_clk;
  end
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (wake === 1'b1)
      wakes <= wakes + 1;
  end

  // Event bits follow the source flag layout; bit 8 is conversion done
  irq_controller u_dut
  (
    .CLK_SYS (clk_sys), .RST_N (rst_n), .HSEL (hsel), .HADDR (haddr),
    .HTRANS (htrans), .HWRITE (hwrite), .HSIZE (3'b010), .HWDATA (hwdata),
    .HREADY (hreadyout), .HRDATA (hrdata), .HREADYOUT (hreadyout),
    .HRESP (hresp), .COMPARATOR_OUT (cmp), .CONV_DONE (ev[8]),
    .NV_WRITE_DONE (ev[7]), .LOW_SUPPLY_DETECT (ev[6]),
    .TIMER_PERIOD_MATCH ({ev[4], ev[2], ev[0]}),
    .TIMER_COMPARE_A ({ev[5], ev[3], ev[1]}),
    .DEDICATED_TICK_CLOCK (tick_clk), .STACK_FULL (full),
    .RETURN_FROM_INTERRUPT (ret), .IRQ_CALL (irq_call),
    .IRQ_VECTOR (irq_vector), .WAKE (wake), .SLOW_XTAL_LOW_POWER (xtal)
  );

  core_model u_core
  (
    .clk (clk_sys), .rst_n (rst_n), .irq_call (irq_call),
    .auto_ret (auto_ret), .hold_full (hold_full), .stack_full (full),
    .ret_pulse (ret)
  );

  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Single word transfer; ends at the edge that completes the data phase
  // No wait limit here: a stuck slave is left to the watchdog
  task bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task rchk(input logic [11:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask

  task pulse(input logic [8:0] m);
    ev <= m;
    @(posedge clk_sys);
    ev <= '0;
    @(posedge clk_sys);
  endtask

  task wait_call(input vector_t v, input int lim);
    int n;
    n = 0;
    while (irq_call !== 1'b1 && n < lim)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk({28'h0, irq_vector}, {28'h0, v});
    @(posedge clk_sys);
  endtask

  task no_call(input int n);
    int c;
    c = 0;
    repeat (n)
    begin
      @(posedge clk_sys);
      if (irq_call !== 1'b0)
        c++;
    end
    chk(c, 0);
  endtask

  task t_reset;
    rchk(`OFS_TICK_CTRL, `TICK_CTRL_RESET);
    rchk(`OFS_IRQ_ENABLE, 8'h00);
    chk(xtal, 1'b0);
    bus(1'b1, 12'h018, 8'hff);
    rchk(12'h018, 8'h00);
    $display("test reset done");
  endtask

  task t_conv;
    int w;
    w = wakes;
    bus(1'b1, `OFS_IRQ_ENABLE, 8'h82);
    pulse(9'h100);
    wait_call(VEC_CONV, 20);
    rchk(`OFS_IRQ_FLAG, 8'h00);
    rchk(`OFS_IRQ_ENABLE, 8'h02);
    chk(wakes - w, 1);
    hold_full <= 1'b1;
    bus(1'b1, `OFS_IRQ_ENABLE, 8'h82);
    pulse(9'h100);
    no_call(20);
    hold_full <= 1'b0;
    wait_call(VEC_CONV, 20);
    $display("test conversion done");
  endtask

  task t_cmp;
    bus(1'b1, `OFS_IRQ_ENABLE, 8'h81);
    cmp <= 1'b1;
    wait_call(VEC_CMP, 20);
    rchk(`OFS_IRQ_FLAG, 8'h00);
    cmp <= 1'b0;
    no_call(10);
    rchk(`OFS_IRQ_FLAG, 8'h01);
    bus(1'b1, `OFS_IRQ_FLAG, 8'h00);
    $display("test comparator done");
  endtask

  task t_groups;
    int g;
    for (int i = 0; i < 8; i++)
    begin
      g = (i < 2) ? 0 : (i < 6) ? 1 : 2;
      bus(1'b1, `OFS_SRC_ENABLE, 8'h00);
      pulse(9'h001 << i);
      rchk(`OFS_SRC_FLAG, 8'h01 << i);
      rchk(`OFS_IRQ_FLAG, 8'h00);
      bus(1'b1, `OFS_SRC_FLAG, 8'h00);
      bus(1'b1, `OFS_SRC_ENABLE, 8'h01 << i);
      bus(1'b1, `OFS_IRQ_ENABLE, 8'h80 | (8'h10 << g));
      pulse(9'h001 << i);
      wait_call(vector_t'(4'd5 + g[3:0]), 20);
      rchk(`OFS_SRC_FLAG, 8'h01 << i);
      rchk(`OFS_IRQ_FLAG, 8'h00);
      bus(1'b1, `OFS_SRC_FLAG, 8'h00);
    end
    $display("test groups done");
  endtask

  task t_prio;
    bus(1'b1, `OFS_SRC_ENABLE, 8'h01);
    bus(1'b1, `OFS_IRQ_ENABLE, 8'h12);
    pulse(9'h101);
    bus(1'b1, `OFS_IRQ_ENABLE, 8'h92);
    wait_call(VEC_GRP0, 20);
    auto_ret <= 1'b1;
    wait_call(VEC_CONV, 20);
    bus(1'b1, `OFS_SRC_FLAG, 8'h00);
    $display("test priority done");
  endtask

  // Measure the spacing of two tick services under one setting
  task span(input vector_t v, input int lim);
    wait_call(v, lim);
    t0 = cyc;
    wait_call(v, lim);
  endtask

  task t_tick;
    bus(1'b1, `OFS_IRQ_ENABLE, 8'h84);
    bus(1'b1, `OFS_TICK_CTRL, 8'hc0);
    span(VEC_TICK0, 1100);
    chk(cyc - t0, 1024);
    bus(1'b1, `OFS_TICK_CTRL, 8'hc1);
    wait_call(VEC_TICK0, 2200);
    span(VEC_TICK0, 2200);
    chk(cyc - t0, 2048);
    bus(1'b1, `OFS_TICK_CTRL, 8'h80);
    span(VEC_TICK0, 1400);
    chk((cyc - t0 >= 1279) && (cyc - t0 <= 1281), 1'b1);
    bus(1'b1, `OFS_IRQ_ENABLE, 8'h88);
    bus(1'b1, `OFS_TICK_CTRL, 8'hc0);
    span(VEC_TICK1, 17000);
    chk(cyc - t0, 16384);
    bus(1'b1, `OFS_TICK_CTRL, 8'h48);
    repeat (10) @(posedge clk_sys);
    bus(1'b1, `OFS_IRQ_FLAG, 8'h00);
    no_call(1500);
    chk(xtal, 1'b1);
    rchk(`OFS_TICK_CTRL, 8'h48);
    $display("test tick timers done");
  endtask

  initial
  begin
    repeat (90000) @(posedge clk_sys);
    num_errors++;
    report_and_stop;
  end

  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset;
    t_conv;
    t_cmp;
    t_groups;
    t_prio;
    t_tick;
    report_and_stop;
  end
endmodule
